// File: slot_assigner_consts.svh
// Purpose: Constants for the receive and transmit time slot assigners
// Assumes: 32-bit AHB-Lite word registers, 125 MHz hclk
// Notes: Offsets are byte addresses
`ifndef SLOT_ASSIGNER_CONSTS_SVH
`define SLOT_ASSIGNER_CONSTS_SVH

`define OFS_RX_COMMAND_STATUS 8'h00
`define OFS_RX_IRQ_CONTROL_WINDOW 8'h04
`define OFS_TX_COMMAND_STATUS 8'h08
`define OFS_TX_IRQ_CONTROL_WINDOW 8'h0C
`define OFS_PORT_PIN_CONTROL 8'h10

`define CMD_FIELD_MSB 15
`define CMD_FIELD_LSB 12
`define CMD_SLOT_DATA 4'h4
`define CMD_CUR_LEVEL 4'h5
`define CMD_IRQ_LEVEL 4'h6
`define CMD_DMA_LEVEL 4'h7

`define WIN_ROUTE_BIT 8
`define WIN_SLOT_MSB 15
`define WIN_SLOT_LSB 9
`define WIN_OFF_MSB 15
`define WIN_OFF_LSB 13
`define WIN_CNT_MSB 12
`define WIN_CNT_LSB 9

`define PCR_TX_GATE_MSB 9
`define PCR_TX_GATE_LSB 8
`define PCR_RX_GATE_MSB 7
`define PCR_RX_GATE_LSB 6
`define PIN_MODE_GATE 2'h1

`define RST_WINDOW_SEL 2'h1
`define RST_PCR 16'h0000
`define BITS_PER_SLOT 10'h008

`endif

// File: slot_assigner_pkg.sv
// Purpose: Types shared by the time slot assigner
// Assumes: Constants come from slot_assigner_consts.svh
// Notes: Index 0 is receive, index 1 is transmit
package slot_assigner_pkg;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_PASS = 2'b10,
    ST_FREE = 2'b11
  } asg_state_t;

  typedef struct packed {
    logic rx_clk_gated;
    logic tx_clk_gated;
    logic port3_out;
    logic port3_oe;
    logic port4_out;
    logic port4_oe;
  } link_pins_t;

  typedef struct packed {
    logic [7:0] rx_level;
    logic [7:0] tx_level;
  } fifo_levels_t;

  typedef struct packed {
    logic [1:0][1:0] win_sel;
    logic [1:0][7:0] icr_low;
    logic [1:0][6:0] slot;
    logic [1:0][2:0] offset;
    logic [1:0][3:0] count;
    logic [1:0][7:0] irq_level;
    logic [1:0][7:0] dma_level;
    logic [15:0] port_pin_control;
    logic [1:0] clk_s1;
    logic [1:0] clk_s2;
    logic [1:0] clk_s3;
    logic fs_s1;
    logic fs_s2;
    asg_state_t [1:0] st;
    logic [1:0][9:0] ctr;
    logic [1:0] gated;
    logic [7:0] addr;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] rdata;
  } asg_regs_t;

endpackage

// File: time_slot_assigner.sv
// Purpose: Receive and transmit time slot assigners with AHB-Lite registers
// Assumes: Bit clocks and frame sync are asynchronous pins, far slower than hclk
// Notes: Bit clocks are gated by edge tracking in hclk, not by clock gating cells
`timescale 1ns/10ps
`include "slot_assigner_consts.svh"

module time_slot_assigner (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link pins
  input wire logic rx_bit_clock,
  input wire logic tx_bit_clock,
  input wire logic frame_sync_n,
  output slot_assigner_pkg::link_pins_t link_pins,
  // FIFO levels from the protocol engines
  input wire slot_assigner_pkg::fifo_levels_t fifo_levels
);
  import slot_assigner_pkg::*;

  asg_regs_t cur_ff;
  asg_regs_t nxt_regs;
  logic [1:0] clk_rise;
  logic [1:0] clk_fall;
  logic [1:0] enabled;
  logic fs_low;
  logic [7:0] cur_level [2];
  logic [31:0] read_value;
  logic addr_take;

  assign clk_rise = cur_ff.clk_s2 & ~cur_ff.clk_s3;
  assign clk_fall = ~cur_ff.clk_s2 & cur_ff.clk_s3;
  assign fs_low = ~cur_ff.fs_s2;
  assign cur_level[0] = fifo_levels.rx_level;
  assign cur_level[1] = fifo_levels.tx_level;
  assign addr_take = hsel & htrans[1] & hready;

  // Transmitter or receiver currently given its clock
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dir
      assign enabled[gi] = (cur_ff.st[gi] == ST_PASS) || (cur_ff.st[gi] == ST_FREE);
    end
  endgenerate

  // Read mux over current state
  always_comb begin
    logic [1:0] d;
    logic [7:0] upper;
    d = 2'h0;
    upper = 8'h00;
    read_value = 32'h0000_0000;
    case (cur_ff.addr)
      `OFS_RX_COMMAND_STATUS, `OFS_TX_COMMAND_STATUS: begin
        d = (cur_ff.addr == `OFS_TX_COMMAND_STATUS) ? 2'h1 : 2'h0;
        read_value[`CMD_FIELD_MSB:`CMD_FIELD_LSB] = {2'h1, cur_ff.win_sel[d[0]]};
        read_value[2:0] = {enabled[d[0]], cur_ff.st[d[0]]};
      end
      `OFS_RX_IRQ_CONTROL_WINDOW, `OFS_TX_IRQ_CONTROL_WINDOW: begin
        d = (cur_ff.addr == `OFS_TX_IRQ_CONTROL_WINDOW) ? 2'h1 : 2'h0;
        case ({2'h1, cur_ff.win_sel[d[0]]})
          `CMD_SLOT_DATA: upper = {cur_ff.slot[d[0]], 1'b0};
          `CMD_CUR_LEVEL: upper = cur_level[d[0]];
          `CMD_IRQ_LEVEL: upper = cur_ff.irq_level[d[0]];
          `CMD_DMA_LEVEL: upper = cur_ff.dma_level[d[0]];
          default: upper = 8'h00;
        endcase
        read_value[15:0] = {upper, cur_ff.icr_low[d[0]]};
      end
      `OFS_PORT_PIN_CONTROL: read_value[15:0] = cur_ff.port_pin_control;
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic dir;
    logic [3:0] cmd;
    logic [9:0] wait_bits;
    logic [9:0] pass_bits;
    dir = 1'b0;
    cmd = 4'h0;
    wait_bits = 10'h000;
    pass_bits = 10'h000;
    nxt_regs = cur_ff;
    // Pin synchronisers; stage one feeds only stage two
    nxt_regs.clk_s1 = {tx_bit_clock, rx_bit_clock};
    nxt_regs.clk_s2 = cur_ff.clk_s1;
    nxt_regs.clk_s3 = cur_ff.clk_s2;
    nxt_regs.fs_s1 = frame_sync_n;
    nxt_regs.fs_s2 = cur_ff.fs_s1;

    for (int i = 0; i < 2; i++) begin
      wait_bits = `BITS_PER_SLOT * {3'h0, cur_ff.slot[i]} + {7'h00, cur_ff.offset[i]};
      pass_bits = `BITS_PER_SLOT * {6'h00, cur_ff.count[i]};
      // Gated copy follows the bit clock only while enabled before the edge
      if (clk_rise[i]) begin
        nxt_regs.gated[i] = enabled[i];
      end else if (clk_fall[i]) begin
        nxt_regs.gated[i] = 1'b0;
      end
      if (cur_ff.count[i] == 4'h0) begin
        nxt_regs.st[i] = ST_FREE;
      end else if (clk_rise[i]) begin
        // Both directions see the same sync sample
        if (fs_low) begin
          if (wait_bits == 10'h000) begin
            nxt_regs.st[i] = ST_PASS;
            nxt_regs.ctr[i] = pass_bits;
          end else begin
            nxt_regs.st[i] = ST_WAIT;
            nxt_regs.ctr[i] = wait_bits;
          end
        end else begin
          case (cur_ff.st[i])
            ST_WAIT: begin
              if (cur_ff.ctr[i] == 10'h001) begin
                nxt_regs.st[i] = ST_PASS;
                nxt_regs.ctr[i] = pass_bits;
              end else begin
                nxt_regs.ctr[i] = cur_ff.ctr[i] - 10'h001;
              end
            end
            ST_PASS: begin
              if (cur_ff.ctr[i] == 10'h001) begin
                nxt_regs.st[i] = ST_HOLD;
              end
              nxt_regs.ctr[i] = cur_ff.ctr[i] - 10'h001;
            end
            ST_FREE: nxt_regs.st[i] = ST_HOLD;
            ST_HOLD: nxt_regs.st[i] = ST_HOLD;
            default: nxt_regs.st[i] = ST_HOLD;
          endcase
        end
      end else if (cur_ff.st[i] == ST_FREE) begin
        // Gating switched back on: wait for the next sync
        nxt_regs.st[i] = ST_HOLD;
      end
    end

    // Reads take one wait state so the data flop sees prior writes
    nxt_regs.rd_pend = 1'b0;
    if (cur_ff.rd_pend) begin
      nxt_regs.rdata = read_value;
    end
    if (cur_ff.wr_pend) begin
      dir = (cur_ff.addr == `OFS_TX_COMMAND_STATUS)
            || (cur_ff.addr == `OFS_TX_IRQ_CONTROL_WINDOW);
      cmd = hwdata[`CMD_FIELD_MSB:`CMD_FIELD_LSB];
      case (cur_ff.addr)
        `OFS_RX_COMMAND_STATUS, `OFS_TX_COMMAND_STATUS: begin
          // Other command codes leave the window alone
          if (cmd[3:2] == 2'h1) begin
            nxt_regs.win_sel[dir] = cmd[1:0];
          end
        end
        `OFS_RX_IRQ_CONTROL_WINDOW, `OFS_TX_IRQ_CONTROL_WINDOW: begin
          nxt_regs.icr_low[dir] = hwdata[7:0];
          case ({2'h1, cur_ff.win_sel[dir]})
            `CMD_SLOT_DATA: begin
              if (hwdata[`WIN_ROUTE_BIT]) begin
                nxt_regs.offset[dir] = hwdata[`WIN_OFF_MSB:`WIN_OFF_LSB];
                nxt_regs.count[dir] = hwdata[`WIN_CNT_MSB:`WIN_CNT_LSB];
              end else begin
                nxt_regs.slot[dir] = hwdata[`WIN_SLOT_MSB:`WIN_SLOT_LSB];
              end
            end
            `CMD_IRQ_LEVEL: nxt_regs.irq_level[dir] = hwdata[15:8];
            `CMD_DMA_LEVEL: nxt_regs.dma_level[dir] = hwdata[15:8];
            default: nxt_regs.irq_level[dir] = cur_ff.irq_level[dir];
          endcase
        end
        `OFS_PORT_PIN_CONTROL: nxt_regs.port_pin_control = hwdata[15:0];
        default: nxt_regs.port_pin_control = cur_ff.port_pin_control;
      endcase
    end
    nxt_regs.wr_pend = 1'b0;
    if (addr_take) begin
      nxt_regs.addr = haddr[7:0];
      nxt_regs.wr_pend = hwrite;
      nxt_regs.rd_pend = ~hwrite;
    end
    if (!clk_en) begin
      nxt_regs = cur_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= '0;
      cur_ff.win_sel <= {`RST_WINDOW_SEL, `RST_WINDOW_SEL};
      cur_ff.port_pin_control <= `RST_PCR;
      cur_ff.clk_s1 <= 2'h0;
      cur_ff.fs_s1 <= 1'b1;
      cur_ff.fs_s2 <= 1'b1;
    end else begin
      cur_ff <= nxt_regs;
    end
  end

  assign hreadyout = ~cur_ff.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = cur_ff.rdata;

  // Outside drivers follow the gate; idle pins are released
  // Gate also covers the last passed pulse, which outlives the state change
  always_comb begin
    link_pins.rx_clk_gated = cur_ff.gated[0];
    link_pins.tx_clk_gated = cur_ff.gated[1];
    link_pins.port4_oe = (cur_ff.port_pin_control[`PCR_TX_GATE_MSB:`PCR_TX_GATE_LSB] == `PIN_MODE_GATE);
    link_pins.port4_out = ~(enabled[1] | cur_ff.gated[1]);
    link_pins.port3_oe = (cur_ff.port_pin_control[`PCR_RX_GATE_MSB:`PCR_RX_GATE_LSB] == `PIN_MODE_GATE);
    link_pins.port3_out = ~(enabled[0] | cur_ff.gated[0]);
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_rx_zero_free: assert property (
    clk_en && cur_ff.count[0] == 4'h0 |=> cur_ff.st[0] == ST_FREE)
    else $error("rx assigner not free with zero count");
  chk_tx_zero_free: assert property (
    clk_en && cur_ff.count[1] == 4'h0 |=> cur_ff.st[1] == ST_FREE)
    else $error("tx assigner not free with zero count");
  chk_rx_wait_load: assert property (
    clk_en && clk_rise[0] && fs_low && cur_ff.count[0] != 4'h0
    && (cur_ff.slot[0] != 7'h00 || cur_ff.offset[0] != 3'h0)
    |=> cur_ff.st[0] == ST_WAIT
    && cur_ff.ctr[0] == {$past(cur_ff.slot[0]), $past(cur_ff.offset[0])})
    else $error("rx wait count wrong after sync");
  chk_rx_zero_open: assert property (
    clk_en && clk_rise[0] && fs_low && cur_ff.count[0] != 4'h0
    && cur_ff.slot[0] == 7'h00 && cur_ff.offset[0] == 3'h0
    |=> cur_ff.st[0] == ST_PASS && cur_ff.ctr[0] == {3'h0, $past(cur_ff.count[0]), 3'h0})
    else $error("rx window not opened at once");
  chk_tx_pass_load: assert property (
    clk_en && clk_rise[1] && !fs_low && cur_ff.st[1] == ST_WAIT && cur_ff.ctr[1] == 10'h001
    && cur_ff.count[1] != 4'h0
    |=> cur_ff.st[1] == ST_PASS && cur_ff.ctr[1] == {3'h0, $past(cur_ff.count[1]), 3'h0})
    else $error("tx pass count wrong");
  chk_tx_close: assert property (
    clk_en && clk_rise[1] && !fs_low && cur_ff.st[1] == ST_PASS && cur_ff.ctr[1] == 10'h001
    && cur_ff.count[1] != 4'h0 |=> cur_ff.st[1] == ST_HOLD)
    else $error("tx window did not close");
  chk_hold_stays: assert property (
    cur_ff.st[0] == ST_HOLD && cur_ff.count[0] != 4'h0 && !(clk_rise[0] && fs_low) && clk_en
    |=> cur_ff.st[0] == ST_HOLD)
    else $error("rx left hold without sync");
  chk_tx_gate_pin: assert property (
    link_pins.port4_out == !(cur_ff.st[1] inside {ST_PASS, ST_FREE} || cur_ff.gated[1]))
    else $error("tx gate mismatch");

  chk_rx_gate_pin: assert property (
    link_pins.port3_out == !(cur_ff.st[0] inside {ST_PASS, ST_FREE} || cur_ff.gated[0]))
    else $error("rx gate mismatch");

  chk_tx_gate_oe: assert property (
    link_pins.port4_oe == (cur_ff.port_pin_control[9:8] == 2'h1))
    else $error("tx gate enable mismatch");

  chk_tx_wait_load: assert property (
    clk_en && clk_rise[1] && fs_low && cur_ff.count[1] != 4'h0
    && (cur_ff.slot[1] != 7'h00 || cur_ff.offset[1] != 3'h0)
    |=> cur_ff.st[1] == ST_WAIT
    && cur_ff.ctr[1] == {$past(cur_ff.slot[1]), $past(cur_ff.offset[1])})
    else $error("tx wait count wrong after sync");

  chk_rx_pass_load: assert property (
    clk_en && clk_rise[0] && !fs_low && cur_ff.st[0] == ST_WAIT && cur_ff.ctr[0] == 10'h001
    && cur_ff.count[0] != 4'h0
    |=> cur_ff.st[0] == ST_PASS && cur_ff.ctr[0] == {3'h0, $past(cur_ff.count[0]), 3'h0})
    else $error("rx pass count wrong");

  chk_rx_close: assert property (
    clk_en && clk_rise[0] && !fs_low && cur_ff.st[0] == ST_PASS && cur_ff.ctr[0] == 10'h001
    && cur_ff.count[0] != 4'h0 |=> cur_ff.st[0] == ST_HOLD)
    else $error("rx window did not close");

  chk_tx_hold_stays: assert property (
    cur_ff.st[1] == ST_HOLD && cur_ff.count[1] != 4'h0 && !(clk_rise[1] && fs_low) && clk_en
    |=> cur_ff.st[1] == ST_HOLD)
    else $error("tx left hold without sync");

  chk_tx_blocked: assert property (
    clk_en && clk_rise[1] && cur_ff.st[1] == ST_HOLD |=> !cur_ff.gated[1] [*2])
    else $error("tx clock passed while blocked");

  chk_tx_free_follow: assert property (
    clk_en && clk_rise[1] && cur_ff.st[1] == ST_FREE |=> cur_ff.gated[1])
    else $error("tx clock not passed while ungated");

  chk_sync_restart: assert property (
    clk_en && clk_rise[1] && fs_low && cur_ff.count[1] != 4'h0
    |=> cur_ff.st[1] inside {ST_WAIT, ST_PASS})
    else $error("tx sync did not restart the frame");
  chk_gated_blocked: assert property (
    clk_en && clk_rise[0] && cur_ff.st[0] == ST_HOLD |=> !cur_ff.gated[0] [*2])
    else $error("rx clock passed while blocked");
  chk_reset_window: assert property (
    $rose(hresetn) |-> cur_ff.win_sel == {`RST_WINDOW_SEL, `RST_WINDOW_SEL})
    else $error("window select wrong after reset");
  chk_read_wait: assert property (
    addr_take && !hwrite && clk_en |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  cov_rx_window: cover property (cur_ff.st[0] == ST_WAIT ##[1:1000] cur_ff.st[0] == ST_PASS);
  cov_tx_close: cover property (cur_ff.st[1] == ST_PASS ##1 cur_ff.st[1] == ST_HOLD);
  cov_slot_read: cover property (cur_ff.rd_pend && cur_ff.win_sel[0] == 2'h0);
  cov_rx_free: cover property (cur_ff.st[0] == ST_FREE && clk_rise[0]);
  cov_tx_restart: cover property (clk_rise[1] && fs_low && cur_ff.st[1] == ST_PASS);
endmodule

// File: frame_sync_source.sv
// Purpose: Far-side frame source driving both bit clocks and frame sync
// Assumes: One free-running link clock of 125 ns, like a T1 line
// Notes: bit_idx is 0 on the rising edge that samples sync low
`timescale 1ns/10ps
module frame_sync_source #(
  parameter int FRAME_BITS = 256
) (
  // Link outputs
  output logic rx_bit_clock,
  output logic tx_bit_clock,
  output logic frame_sync_n,
  // Bit position within the frame
  output int unsigned bit_idx
);
  logic bclk;

  initial begin
    bclk = 1'b0;
    frame_sync_n = 1'b1;
    bit_idx = 0;
    forever #62.5 bclk = ~bclk;
  end

  // Both directions share one source, so one sync fits both
  assign rx_bit_clock = bclk;
  assign tx_bit_clock = bclk;

  // Moved on the falling edge so it is stable at the sampling edge
  always @(negedge bclk) frame_sync_n <= (bit_idx != FRAME_BITS - 1);

  always @(posedge bclk) bit_idx <= (frame_sync_n == 1'b0) ? 0 : bit_idx + 1;
endmodule

// File: tb_time_slot_assigner.sv
// Purpose: Self-checking bench for the time slot assigners
// Assumes: Sync every 256 bits, first slot right after sync
// Notes: Edge positions of gated clocks come from the frame source
`timescale 1ns/10ps
module tb_time_slot_assigner;
  import slot_assigner_pkg::*;
  localparam int FB = 256;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic rx_bit_clock, tx_bit_clock, frame_sync_n;
  logic [1:0] gate;
  int unsigned bit_idx;
  link_pins_t link_pins;
  fifo_levels_t fifo_levels;
  int fail_count, n_checks, frames, live;
  int cnt_g[2], first_g[2], snap_cnt[2], snap_first[2];
  int exp_first[2], exp_n[2], exp_last[2];

  assign gate = {link_pins.port4_out, link_pins.port3_out};

  time_slot_assigner u_time_slot_assigner (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_bit_clock(rx_bit_clock), .tx_bit_clock(tx_bit_clock),
    .frame_sync_n(frame_sync_n), .link_pins(link_pins), .fifo_levels(fifo_levels));
  frame_sync_source #(.FRAME_BITS(FB)) u_frame_sync_source (.rx_bit_clock(rx_bit_clock),
    .tx_bit_clock(tx_bit_clock), .frame_sync_n(frame_sync_n), .bit_idx(bit_idx));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_n(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input string what, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic reset_view();
    bus(1'b0, 8'h00, 32'h0);
    chk("rx command", 32'h00005000, rd & 32'hFFFFF000);
    bus(1'b0, 8'h0C, 32'h0);
    chk("tx window", 32'h00003C00, rd & 32'hFFFFFF00);
    bus(1'b1, 8'h04, 32'h0000FF5A);
    rd_chk(8'h04, "rx window low byte", 32'h0000A55A);
  endtask

  task automatic window_cmds();
    logic [7:0] cs, w;
    for (int d = 0; d < 2; d++) begin
      cs = 8'(d * 8);
      w = cs + 8'h04;
      bus(1'b1, cs, 32'h00006000);
      bus(1'b1, w, 32'h00007700);
      bus(1'b1, cs, 32'h00007000);
      bus(1'b1, w, 32'h00003300);
      bus(1'b1, cs, 32'h00004000);
      bus(1'b1, w, 32'h0000AA00);
      bus(1'b1, w, 32'h0000FF00);
      rd_chk(w, "slot data", 32'h0000AA00);
      bus(1'b1, cs, 32'h00006000);
      rd_chk(w, "irq level", 32'h00007700);
      bus(1'b1, cs, 32'h00007000);
      rd_chk(w, "dma level", 32'h00003300);
      bus(1'b1, cs, 32'h00005000);
      rd_chk(w, "current level", (d == 1) ? 32'h00003C00 : 32'h0000A500);
      bus(1'b1, cs, 32'h00004000);
      bus(1'b1, cs, 32'h00002000);
      rd_chk(w, "slot data again", 32'h0000AA00);
    end
  endtask

  task automatic pins_unmapped();
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, "unmapped", 32'h0);
    bus(1'b1, 8'h10, 32'h00000140);
    // Write lands on the edge that ends the data phase
    @(negedge hclk);
    chk("gate enables on", 32'h3, {30'h0, link_pins.port4_oe, link_pins.port3_oe});
    bus(1'b1, 8'h10, 32'h00000280);
    @(negedge hclk);
    chk("gate enables off", 32'h0, {30'h0, link_pins.port4_oe, link_pins.port3_oe});
    bus(1'b1, 8'h10, 32'h00000140);
    rd_chk(8'h10, "port control", 32'h00000140);
    chk("gate enables on", 32'h3, {30'h0, link_pins.port4_oe, link_pins.port3_oe});
  endtask

  task automatic cfg(input int d, input logic [6:0] s, input logic [2:0] o, input logic [3:0] c);
    bus(1'b1, 8'(d * 8), 32'h00004000);
    bus(1'b1, 8'(d * 8 + 4), {16'h0, s, 1'b0, 8'h00});
    bus(1'b1, 8'(d * 8 + 4), {16'h0, o, c, 1'b1, 8'h00});
    exp_first[d] = (c == 0) ? 0 : 8 * int'(s) + int'(o) + 1;
    exp_n[d] = (c == 0) ? FB : 8 * int'(c);
    exp_last[d] = exp_first[d] + exp_n[d] - 1;
  endtask

  task automatic gating(input logic [6:0] rs, input logic [2:0] ro, input logic [3:0] rc,
                        input logic [6:0] ts, input logic [2:0] tof, input logic [3:0] tc);
    int f0;
    live = 0;
    cfg(0, rs, ro, rc);
    cfg(1, ts, tof, tc);
    f0 = frames;
    wait (frames == f0 + 1);
    live = 1;
    wait (frames == f0 + 2);
    live = 0;
    for (int d = 0; d < 2; d++) begin
      chk_n("passed clocks", exp_n[d], snap_cnt[d]);
      chk_n("first passed edge", exp_first[d], snap_first[d]);
    end
  endtask

  task automatic note(input int d);
    if (cnt_g[d] == 0) first_g[d] = bit_idx;
    cnt_g[d]++;
    // Pin read from the same struct update as the gated clock, free of races
    if (live == 1)
      chk("gate at passed clock", 32'h0,
          {31'h0, (d == 1) ? link_pins.port4_out : link_pins.port3_out});
  endtask

  always @(posedge link_pins.rx_clk_gated) note(0);
  always @(posedge link_pins.tx_clk_gated) note(1);

  // Gate is judged 60 ns into the 125 ns bit, just before the falling edge, clear of the synchroniser delay
  always @(posedge rx_bit_clock) begin
    #1;
    if (bit_idx == 0) begin
      snap_cnt = cnt_g;
      snap_first = first_g;
      cnt_g = '{0, 0};
      frames++;
    end
    #59;
    for (int d = 0; d < 2; d++)
      if (live == 1 && exp_n[d] != FB && (bit_idx == exp_last[d] + 2 ||
          (exp_first[d] > 3 && bit_idx == exp_first[d] - 3)))
        chk("gate outside window", 32'h1, {31'h0, gate[d]});
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fifo_levels = 16'hA53C;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    reset_view();
    window_cmds();
    pins_unmapped();
    gating(7'h01, 3'h0, 4'h1, 7'h00, 3'h0, 4'h2);
    gating(7'h02, 3'h7, 4'hF, 7'h00, 3'h0, 4'h0);
    gating(7'h00, 3'h0, 4'h0, 7'h03, 3'h5, 4'h4);
    conclude();
  end

  initial begin
    #600000;
    fail_count++;
    conclude();
  end
endmodule
